// ### verilog/pm_csr_pkg.sv
package pm_csr_pkg;
    // one dword of configuration space holds all three registers
    localparam logic [7:0] PM_CSR_OFFSET      = 8'he0;
    localparam logic [7:0] BRIDGE_EXT_OFFSET  = 8'he2;
    localparam logic [7:0] REPORT_DATA_OFFSET = 8'he3;
    localparam logic [5:0] CFG_WORD_INDEX     = PM_CSR_OFFSET[7:2];

    // field positions inside the dword
    localparam int STATE_LSB       = 0;
    localparam int DYN_FLAG_BIT    = 4;
    localparam int WAKE_EN_BIT     = 8;
    localparam int SEL_LSB         = 9;
    localparam int SCALE_LSB       = 13;
    localparam int WAKE_STATUS_BIT = 15;
    localparam int BRIDGE_EXT_LSB  = 16;
    localparam int REPORT_LSB      = 24;

    // reset and constant values
    localparam logic [1:0] STATE_RESET       = 2'h0;
    localparam logic [3:0] SEL_RESET         = 4'h0;
    localparam logic [1:0] SCALE_RESET       = 2'h0;
    localparam logic [7:0] BRIDGE_EXT_VALUE  = 8'h00;
    localparam logic [7:0] REPORT_RESET      = 8'h00;
    localparam logic [3:0] WAKE_CAP_RESET    = 4'h0;

    // preload port map
    localparam int          DATA_BYTES          = 8;
    localparam logic [3:0]  PRELOAD_CAPS_INDEX  = 4'h8;
    localparam logic [3:0]  PRELOAD_SCALE_INDEX = 4'h9;
    localparam int          CAP_LIGHT_BIT       = 0;
    localparam int          CAP_DEEP_BIT        = 1;
    localparam int          CAP_WAKE_LSB        = 2;
    localparam int          CAP_REPORT_BIT      = 6;

    typedef enum logic [1:0] {
        PS_D0 = 2'h0,
        PS_D1 = 2'h1,
        PS_D2 = 2'h2,
        PS_D3 = 2'h3
    } power_state_e;
endpackage : pm_csr_pkg

// ### verilog/cfg_port.sv
`timescale 1ns/10ps
`default_nettype none
module cfg_port
    import pm_csr_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // configuration access
    input  wire logic        sel,
    input  wire logic        write,
    input  wire logic [5:0]  addr,
    input  wire logic [3:0]  byteEn,
    input  wire logic [31:0] readWord,
    // answer
    output logic      [31:0] rdata,
    output logic             ack,
    output logic      [3:0]  wrBytes
);
    logic hit;

    assign hit     = sel && (addr == CFG_WORD_INDEX);
    assign wrBytes = (hit && write) ? byteEn : 4'h0;

    // every access completes, whatever it hits or discards
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ack <= 1'b0;
        end else begin
            ack <= sel; // RULE2
        end
    end

    // unmapped dwords read zero; data holds until the next read
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdata <= 32'h0;
        end else if (sel && !write) begin
            rdata <= hit ? readWord : 32'h0;
        end
    end
endmodule : cfg_port
`default_nettype wire

// ### verilog/preload_store.sv
`timescale 1ns/10ps
`default_nettype none
module preload_store
    import pm_csr_pkg::*;
#(
    parameter int BYTES = DATA_BYTES
)(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset,
    // serial rom or local processor load
    input  wire logic                  loadWrite,
    input  wire logic [3:0]            loadIndex,
    input  wire logic [7:0]            loadData,
    // loaded values
    output logic [BYTES-1:0][7:0]      dataBytes,
    output logic                       lightSleep,
    output logic                       deepSleep,
    output logic [3:0]                 wakeCapable,
    output logic                       reportEnable,
    output logic [1:0]                 dataScale
);
    genvar i;
    generate
        for (i = 0; i < BYTES; i++) begin : g_byte
            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    dataBytes[i] <= 8'h00;
                end else if (loadWrite && loadIndex == 4'(i)) begin
                    dataBytes[i] <= loadData;
                end
            end
        end
    endgenerate

    // both optional states start unsupported
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            lightSleep   <= 1'b0; // RULE16
            deepSleep    <= 1'b0; // RULE16
            wakeCapable  <= WAKE_CAP_RESET;
            reportEnable <= 1'b0;
        end else if (loadWrite && loadIndex == PRELOAD_CAPS_INDEX) begin
            lightSleep   <= loadData[CAP_LIGHT_BIT]; // RULE16
            deepSleep    <= loadData[CAP_DEEP_BIT]; // RULE16
            wakeCapable  <= loadData[CAP_WAKE_LSB +: 4];
            reportEnable <= loadData[CAP_REPORT_BIT];
        end
    end

    // scale is only reachable from this port
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dataScale <= SCALE_RESET; // RULE10
        end else if (loadWrite && loadIndex == PRELOAD_SCALE_INDEX) begin
            dataScale <= loadData[1:0]; // RULE10
        end
    end
endmodule : preload_store
`default_nettype wire

// ### verilog/pci_power_mgmt_csr.sv
`timescale 1ns/10ps
`default_nettype none
//Behaviour
// RULE1: two-bit power state, D0..D3 as 0..3, resets to D0.
// RULE2: write of unsupported state completes but leaves the field unchanged.
// RULE3: D0 and D3 always accepted; D1, D2 only when preloaded as supported.
// RULE4: bits 3:2 and 7:5 of the control/status register read zero.
// RULE5: dynamic data flag at bit 4 reads zero.
// RULE6: wake enable reads zero, ignores writes, while no wake-capable bit set.
// RULE7: wake enable low never drives the upstream wake; resets to zero.
// RULE8: data selector works only with report enable preloaded; else reads zero.
// RULE9: selector 0..7 picks a preloaded byte; 8..15 give zero data.
// RULE10: data scale read-only from config, loaded by preload, resets zero.
// RULE11: wake status sets on downstream wake when current state is capable.
// RULE12: wake status cleared by writing one; zero ignored; resets zero.
// RULE13: bridge extension byte is constant zero; writes ignored.
// RULE14: report data byte shows selected byte or zero; resets zero.
// RULE15: wake-capable bits map D0 upward; the D3cold bit is always zero.
// RULE16: light and deep sleep capability bits preloaded, default unsupported.
// RULE17: both config sides see and write one shared register copy.
module pci_power_mgmt_csr
    import pm_csr_pkg::*;
#(
    parameter int BYTES = DATA_BYTES
)(
    // clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    // configuration ports, index 0 primary, 1 secondary
    input  wire logic [1:0]       cfgSel,
    input  wire logic [1:0]       cfgWrite,
    input  wire logic [1:0][5:0]  cfgAddr,
    input  wire logic [1:0][3:0]  cfgByteEn,
    input  wire logic [1:0][31:0] cfgWData,
    output logic      [1:0][31:0] cfgRData,
    output logic      [1:0]       cfgAck,
    // serial rom or local processor preload
    input  wire logic             loadWrite,
    input  wire logic [3:0]       loadIndex,
    input  wire logic [7:0]       loadData,
    // wake pins
    input  wire logic             downWakeN,
    output logic                  upWakeOut,
    output logic                  upWakeOeN
);
    logic [BYTES-1:0][7:0] dataBytes;
    logic                  lightSleep;
    logic                  deepSleep;
    logic [3:0]            wakeCapable;
    logic                  reportEnable;
    logic [1:0]            dataScale;
    logic [1:0][3:0]       wrBytes;
    power_state_e          powerState;
    logic                  wakeEnable;
    logic [3:0]            dataSel;
    logic                  wakeStatus;
    logic                  anyCap;
    logic                  wakeEnView;
    logic                  wakeHit;
    logic [7:0]            reportByte;
    logic [31:0]           readWord;
    logic                  stateWr;
    logic [1:0]            stateReq;
    logic                  enWr;
    logic                  enReq;
    logic                  selWr;
    logic [3:0]            selReq;
    logic                  wakeClear;
    logic                  stateLegal;

    preload_store #(
        .BYTES (BYTES)
    ) u_preload (
        .clock        (clock),
        .reset        (reset),
        .loadWrite    (loadWrite),
        .loadIndex    (loadIndex),
        .loadData     (loadData),
        .dataBytes    (dataBytes),
        .lightSleep   (lightSleep),
        .deepSleep    (deepSleep),
        .wakeCapable  (wakeCapable),
        .reportEnable (reportEnable),
        .dataScale    (dataScale)
    );

    // same decode on both sides, one shared copy behind them
    genvar s;
    generate
        for (s = 0; s < 2; s++) begin : g_side
            cfg_port u_port (
                .clock    (clock),
                .reset    (reset),
                .sel      (cfgSel[s]),
                .write    (cfgWrite[s]),
                .addr     (cfgAddr[s]),
                .byteEn   (cfgByteEn[s]),
                .readWord (readWord), // RULE17
                .rdata    (cfgRData[s]),
                .ack      (cfgAck[s]),
                .wrBytes  (wrBytes[s])
            );
        end
    endgenerate

    // merge both sides; secondary wins a same-cycle collision
    always_comb begin
        stateWr   = 1'b0;
        stateReq  = 2'h0;
        enWr      = 1'b0;
        enReq     = 1'b0;
        selWr     = 1'b0;
        selReq    = 4'h0;
        wakeClear = 1'b0;
        for (int i = 0; i < 2; i++) begin
            if (wrBytes[i][0]) begin
                stateWr  = 1'b1; // RULE17
                stateReq = cfgWData[i][STATE_LSB +: 2];
            end
            if (wrBytes[i][1]) begin
                enWr   = 1'b1;
                enReq  = cfgWData[i][WAKE_EN_BIT];
                selWr  = 1'b1;
                selReq = cfgWData[i][SEL_LSB +: 4];
                if (cfgWData[i][WAKE_STATUS_BIT]) begin
                    wakeClear = 1'b1; // RULE12
                end
            end
        end
    end

    always_comb begin
        case (stateReq)
            PS_D0:   stateLegal = 1'b1; // RULE3
            PS_D1:   stateLegal = lightSleep; // RULE3
            PS_D2:   stateLegal = deepSleep; // RULE3
            PS_D3:   stateLegal = 1'b1; // RULE3
            default: stateLegal = 1'b0;
        endcase
    end

    // an illegal request is dropped silently, the access still acks
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            powerState <= PS_D0; // RULE1
        end else if (stateWr && stateLegal) begin
            powerState <= power_state_e'(stateReq); // RULE2
        end
    end

    assign anyCap     = |wakeCapable;
    assign wakeEnView = wakeEnable && anyCap; // RULE6

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wakeEnable <= 1'b0; // RULE7
        end else if (enWr && anyCap) begin
            wakeEnable <= enReq; // RULE6
        end
    end

    // selector holds its value unless reporting is enabled
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dataSel <= SEL_RESET; // RULE8
        end else if (selWr && reportEnable) begin
            dataSel <= selReq; // RULE8
        end
    end

    // no D3cold bit is held, so that state can never wake
    assign wakeHit = !downWakeN && wakeCapable[powerState]; // RULE11 RULE15

    // a wake in the clearing cycle is kept: set beats clear
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wakeStatus <= 1'b0; // RULE12
        end else if (wakeHit) begin
            wakeStatus <= 1'b1; // RULE11
        end else if (wakeClear) begin
            wakeStatus <= 1'b0; // RULE12
        end
    end

    // open drain: pin only ever pulled low
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            upWakeOut <= 1'b0;
            upWakeOeN <= 1'b1;
        end else begin
            upWakeOut <= 1'b0;
            upWakeOeN <= !(wakeEnView && wakeStatus); // RULE7
        end
    end

    always_comb begin
        reportByte = REPORT_RESET;
        if (reportEnable && !dataSel[3]) begin
            reportByte = dataBytes[dataSel[2:0]]; // RULE9 RULE14
        end
    end

    always_comb begin
        readWord = 32'h0; // RULE4 RULE5
        readWord[STATE_LSB +: 2]        = powerState;
        readWord[WAKE_EN_BIT]           = wakeEnView; // RULE6
        readWord[SEL_LSB +: 4]          = reportEnable ? dataSel : 4'h0;
        readWord[SCALE_LSB +: 2]        = dataScale; // RULE10
        readWord[WAKE_STATUS_BIT]       = wakeStatus;
        readWord[BRIDGE_EXT_LSB +: 8]   = BRIDGE_EXT_VALUE; // RULE13
        readWord[REPORT_LSB +: 8]       = reportByte; // RULE14
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    chk_state_reject: assert property ( // RULE2
        stateWr && !stateLegal |=> $stable(powerState))
        else $error("illegal power state was stored");

    chk_state_accept: assert property ( // RULE3
        stateWr && stateLegal |=> powerState == $past(stateReq))
        else $error("legal power state was not stored");

    chk_light_guard: assert property ( // RULE3
        stateWr && stateReq == PS_D1 && !lightSleep |=> powerState != PS_D1)
        else $error("D1 taken without support");

    chk_reserved_zero: assert property ( // RULE4
        readWord[7:5] == 3'h0 && readWord[3:2] == 2'h0)
        else $error("reserved bits not zero");

    chk_dyn_flag: assert property ( // RULE5
        !readWord[DYN_FLAG_BIT])
        else $error("dynamic data flag set");

    chk_wake_en_gate: assert property ( // RULE6
        !anyCap |-> !readWord[WAKE_EN_BIT])
        else $error("wake enable visible without capability");

    chk_wake_out_gate: assert property ( // RULE7
        !wakeEnView |=> upWakeOeN)
        else $error("upstream wake driven while disabled");

    chk_wake_out_on: assert property ( // RULE7
        wakeEnView && wakeStatus |=> !upWakeOeN && !upWakeOut)
        else $error("upstream wake not driven");

    chk_sel_gate: assert property ( // RULE8
        !reportEnable |-> readWord[SEL_LSB +: 4] == 4'h0)
        else $error("selector visible while disabled");

    chk_data_range: assert property ( // RULE9
        dataSel[3] |-> readWord[REPORT_LSB +: 8] == 8'h00)
        else $error("out of range selector gave data");

    chk_status_set: assert property ( // RULE11
        wakeHit |=> wakeStatus [*1] ##0 readWord[WAKE_STATUS_BIT])
        else $error("wake status not set");

    chk_status_hold: assert property ( // RULE12
        wakeStatus && !wakeClear |=> wakeStatus)
        else $error("wake status dropped without clear");

    chk_status_clear: assert property ( // RULE12
        wakeStatus && wakeClear && !wakeHit |=> !wakeStatus)
        else $error("wake status not cleared");

    chk_bridge_zero: assert property ( // RULE13
        readWord[BRIDGE_EXT_LSB +: 8] == 8'h00)
        else $error("bridge extension byte not zero");

    chk_sides_agree: assert property ( // RULE17
        cfgSel == 2'h3 && cfgWrite == 2'h0 && cfgAddr[0] == cfgAddr[1]
        |=> cfgRData[0] == cfgRData[1] && cfgAck == 2'h3)
        else $error("sides disagree on read");

    chk_sel_frozen: assert property ( // RULE8
        !reportEnable |=> $stable(dataSel))
        else $error("selector moved while reporting disabled");

    chk_report_off: assert property ( // RULE14
        !reportEnable |-> readWord[REPORT_LSB +: 8] == 8'h00)
        else $error("report data shown while disabled");

    chk_wake_en_lock: assert property ( // RULE6
        !anyCap |=> $stable(wakeEnable))
        else $error("wake enable stored without capability");

    chk_status_source: assert property ( // RULE11
        !wakeStatus && !wakeHit |=> !wakeStatus)
        else $error("wake status set with no wake");

    chk_scale_readonly: assert property ( // RULE10
        !loadWrite |=> $stable(dataScale))
        else $error("data scale changed by config access");

    cov_wake_set:    cover property (wakeHit ##1 wakeStatus);
    cov_enter_d3:    cover property (stateWr && stateReq == PS_D3 ##1
                                     powerState == PS_D3);
    cov_clear_wake:  cover property (wakeStatus && wakeClear ##1 !wakeStatus);
    cov_both_write:  cover property (wrBytes[0] != 4'h0 &&
                                     wrBytes[1] != 4'h0);
    cov_sides_read:  cover property (cfgSel == 2'h3 && cfgWrite == 2'h0
                                     ##1 cfgAck == 2'h3);
endmodule : pci_power_mgmt_csr
`default_nettype wire

// ### dv/pci_power_mgmt_csr_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module pci_power_mgmt_csr_tb_top
    import pm_csr_pkg::*;
;
    // clock and reset
    logic             clock;
    logic             reset;
    // configuration sides
    logic [1:0]       cfgSel;
    logic [1:0]       cfgWrite;
    logic [1:0][5:0]  cfgAddr;
    logic [1:0][3:0]  cfgByteEn;
    logic [1:0][31:0] cfgWData;
    logic [1:0][31:0] cfgRData;
    logic [1:0]       cfgAck;
    // preload and wake
    logic             loadWrite;
    logic [3:0]       loadIndex;
    logic [7:0]       loadData;
    logic             downWakeN;
    logic             upWakeOut;
    logic             upWakeOeN;
    // bench state
    int               failures;
    int               tests_run;
    logic [31:0]      got;
    logic [1:0]       st;
    logic [7:0]       pre [DATA_BYTES];

    pci_power_mgmt_csr #(
        .BYTES(DATA_BYTES)
    ) dut (
        .clock     (clock),
        .reset     (reset),
        .cfgSel    (cfgSel),
        .cfgWrite  (cfgWrite),
        .cfgAddr   (cfgAddr),
        .cfgByteEn (cfgByteEn),
        .cfgWData  (cfgWData),
        .cfgRData  (cfgRData),
        .cfgAck    (cfgAck),
        .loadWrite (loadWrite),
        .loadIndex (loadIndex),
        .loadData  (loadData),
        .downWakeN (downWakeN),
        .upWakeOut (upWakeOut),
        .upWakeOeN (upWakeOeN)
    );

    initial clock = 1'b0;
    always #20 clock = ~clock;

    task automatic tally_and_finish;
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h, expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // expected dword, built field by field
    function automatic logic [31:0] pm(input logic [1:0] sv,
        input logic en, input logic [3:0] sl, input logic [1:0] sc,
        input logic stat, input logic [7:0] rpt);
        return {rpt, BRIDGE_EXT_VALUE, stat, sc, sl, en, 6'h00, sv};
    endfunction : pm

    // one access, strobe for a single cycle, answer one cycle later
    task automatic cfg(input int s, input logic wr, input logic [3:0] be,
                       input logic [5:0] a, input logic [31:0] wd);
        @(negedge clock);
        cfgSel[s]    = 1'b1;
        cfgWrite[s]  = wr;
        cfgAddr[s]   = a;
        cfgByteEn[s] = be;
        cfgWData[s]  = wd;
        @(posedge clock);
        @(negedge clock);
        check({31'h0, cfgAck[s]}, 32'h1);
        got       = cfgRData[s];
        cfgSel[s] = 1'b0;
    endtask : cfg

    task automatic wr(input int s, input logic [3:0] be,
                      input logic [31:0] wd);
        cfg(s, 1'b1, be, CFG_WORD_INDEX, wd);
    endtask : wr

    task automatic rd(input int s, input logic [31:0] exp);
        cfg(s, 1'b0, 4'hf, CFG_WORD_INDEX, 32'h0);
        check(got, exp);
    endtask : rd

    task automatic load(input logic [3:0] i, input logic [7:0] d);
        @(negedge clock);
        loadWrite = 1'b1;
        loadIndex = i;
        loadData  = d;
        @(negedge clock);
        loadWrite = 1'b0;
    endtask : load

    // wake input is a level, one cycle low is enough to latch status
    task automatic wake;
        @(negedge clock);
        downWakeN = 1'b0;
        @(negedge clock);
        downWakeN = 1'b1;
    endtask : wake

    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        tally_and_finish();
    end

    initial begin
        failures  = 0;
        tests_run = 0;
        reset     = 1'b1;
        cfgSel    = '0;
        cfgWrite  = '0;
        cfgAddr   = '0;
        cfgByteEn = '0;
        cfgWData  = '0;
        loadWrite = 1'b0;
        loadIndex = 4'h0;
        loadData  = 8'h00;
        downWakeN = 1'b1;
        st        = 2'h0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        check({30'h0, upWakeOut, upWakeOeN}, 32'h1);
        rd(0, 32'h0);
        // all ones above the state field: only legal states may land
        for (int v = 0; v < 4; v++) begin
            wr(v % 2, 4'hf, 32'hffff_fffc | v);
            if (v == 0 || v == 3) begin
                st = v[1:0];
            end
            rd(1 - v % 2, pm(st, 1'b0, 4'h0, 2'h0, 1'b0, 8'h00));
        end
        cfg(0, 1'b0, 4'hf, 6'h37, 32'h0);
        check(got, 32'h0);
        for (int i = 0; i < DATA_BYTES; i++) begin
            pre[i] = 8'ha0 + 8'(i);
            load(i[3:0], pre[i]);
        end
        load(PRELOAD_CAPS_INDEX, 8'h43);
        load(PRELOAD_SCALE_INDEX, 8'h02);
        for (int v = 1; v < 3; v++) begin
            wr(0, 4'h1, v);
            rd(1, pm(v[1:0], 1'b0, 4'h0, 2'h2, 1'b0, pre[0]));
        end
        // every selector code, enable write refused without wake caps
        for (int s = 0; s < 16; s++) begin
            wr(s % 2, 4'h2, {19'h0, s[3:0], 9'h100});
            rd(0, pm(2'h2, 1'b0, s[3:0], 2'h2, 1'b0,
                     s < 8 ? pre[s] : 8'h00));
        end
        load(PRELOAD_CAPS_INDEX, 8'h47);
        wr(0, 4'h1, 32'h0);
        wake();
        repeat (3) begin
            @(negedge clock);
            check({31'h0, upWakeOeN}, 32'h1);
        end
        rd(0, pm(2'h0, 1'b0, 4'hf, 2'h2, 1'b1, 8'h00));
        wr(1, 4'h2, 32'h0000_1e00);
        rd(0, pm(2'h0, 1'b0, 4'hf, 2'h2, 1'b1, 8'h00));
        wr(1, 4'h2, 32'h0000_9e00);
        rd(0, pm(2'h0, 1'b0, 4'hf, 2'h2, 1'b0, 8'h00));
        // D3 has no wake capability loaded, so no status
        wr(0, 4'h1, 32'h3);
        wake();
        rd(1, pm(2'h3, 1'b0, 4'hf, 2'h2, 1'b0, 8'h00));
        wr(0, 4'h3, 32'h0000_1f00);
        rd(1, pm(2'h0, 1'b1, 4'hf, 2'h2, 1'b0, 8'h00));
        check({31'h0, upWakeOeN}, 32'h1);
        wake();
        @(negedge clock);
        check({30'h0, upWakeOut, upWakeOeN}, 32'h0);
        wr(0, 4'h2, 32'h0000_9f00);
        rd(0, pm(2'h0, 1'b1, 4'hf, 2'h2, 1'b0, 8'h00));
        check({31'h0, upWakeOeN}, 32'h1);
        // both sides in one cycle: secondary state wins, both read back
        @(negedge clock);
        cfgSel    = 2'h3;
        cfgWrite  = 2'h3;
        cfgAddr   = {CFG_WORD_INDEX, CFG_WORD_INDEX};
        cfgByteEn = 8'h11;
        cfgWData  = {32'h3, 32'h0};
        @(negedge clock);
        check({30'h0, cfgAck}, 32'h3);
        cfgWrite  = 2'h0;
        @(negedge clock);
        check({30'h0, cfgAck}, 32'h3);
        got = pm(2'h3, 1'b1, 4'hf, 2'h2, 1'b0, 8'h00);
        check(cfgRData[0], got);
        check(cfgRData[1], got);
        cfgSel    = 2'h0;
        // second reset in mid-run clears fields and preloaded support
        @(negedge clock);
        reset = 1'b1;
        @(negedge clock);
        reset = 1'b0;
        check({30'h0, upWakeOut, upWakeOeN}, 32'h1);
        rd(0, 32'h0);
        // caps back but enable must have been cleared by reset
        load(PRELOAD_CAPS_INDEX, 8'h04);
        rd(0, 32'h0);
        wr(1, 4'h1, 32'h1);
        rd(0, 32'h0);
        tally_and_finish();
    end
endmodule : pci_power_mgmt_csr_tb_top
`default_nettype wire
